//--- rtl/sscr_pkg.sv
// sscr_pkg: constants, codes and the checksum step for the serial command responder.
// assumes a 200 MHz core clock and a byte-wide serial link.
package sscr_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int unsigned CLK_HZ         = 200_000_000;
	localparam int unsigned BAUD_BPS       = 19_200;
	// a bit time rounds down to whole cycles
	localparam int unsigned BIT_CYCLES     = CLK_HZ / BAUD_BPS;
	localparam int unsigned BITS_PER_BYTE  = 10;
	localparam int unsigned GAP_BYTE_TIMES = 2;
	// reply start bound; our reply follows the gap by a few cycles, far inside it
	localparam int unsigned REPLY_LIMIT_MS = 20;
	localparam int unsigned DATA_BITS      = 8;

	////////////////////////////////////////////////////////////////////////////////
	// frame layout and codes
	localparam logic [7:0] BCAST_ADDR     = 8'h00;
	localparam logic [7:0] DEFAULT_ADDR   = 8'h64;
	localparam logic [7:0] CODE_TEST      = 8'h04;
	localparam logic [7:0] CODE_MRST      = 8'h05;
	localparam logic [7:0] CODE_RESTART   = 8'h07;
	localparam logic [7:0] CODE_ADDR      = 8'h11;
	localparam logic [7:0] CODE_IDENT     = 8'h20;
	localparam logic [7:0] LEN_NONE       = 8'h00;
	localparam logic [7:0] LEN_ONE        = 8'h01;
	localparam logic [7:0] LEN_TWO        = 8'h02;
	localparam logic [7:0] LEN_IDENT      = 8'h08;
	localparam logic [7:0] RES_FAIL       = 8'h00;
	localparam logic [7:0] RES_ACCEPT     = 8'h01;
	localparam logic [7:0] RES_BUSY       = 8'h02;
	localparam logic [8:0] FRAME_OVERHEAD = 9'h005;
	localparam logic [8:0] BYTE_CNT_MAX   = 9'h1ff;

	////////////////////////////////////////////////////////////////////////////////
	// status byte bit positions
	localparam int unsigned FLT_CHIP_BIT   = 5;
	localparam int unsigned FLT_GAIN_BIT   = 4;
	localparam int unsigned FLT_OFFS_BIT   = 3;
	localparam int unsigned FLT_FDBK_BIT   = 2;
	localparam int unsigned FLT_OSC_BIT    = 1;
	localparam int unsigned FLT_CFG_BIT    = 0;
	localparam int unsigned CFG_STD_BIT    = 3;
	localparam int unsigned CFG_CLK_BIT    = 2;
	localparam int unsigned CFG_SPI_BIT    = 1;
	localparam int unsigned CFG_RECL_BIT   = 0;

	////////////////////////////////////////////////////////////////////////////////
	// checksum: reflected form of 0x18005, table-free
	localparam logic [15:0] CRC_POLY_REFL = 16'ha001;
	localparam logic [15:0] CRC_INIT      = 16'h0000;
	localparam int unsigned FIFO_WIDTH    = 8;
	localparam int unsigned FIFO_DEPTH    = 8;

	function automatic logic [15:0] sscr_crc_byte(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
		end
		return c;
	endfunction

endpackage

//--- rtl/sscr_stream_if.sv
// sscr_stream_if: valid/ready byte stream between responder and its reply fifo.
// assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface sscr_stream_if #(
	parameter int unsigned W = 8
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- rtl/sscr_fifo.sv
// sscr_fifo: small synchronous fifo with valid/ready on both sides.
// assumes one clock; clock enable low freezes all state.
`timescale 1ns/1ps
`default_nettype none
module sscr_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic     core_clk_i,
	input  wire logic     nrst_i,
	input  wire logic     ce_i,
	sscr_stream_if.snk    wr,
	sscr_stream_if.src    rd
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wptr;
	logic [AW:0]      rptr;
	logic             full;
	logic             empty;

	// extra pointer bit tells full from empty
	assign empty    = (wptr == rptr);
	assign full     = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data  = mem[rptr[AW-1:0]];

	////////////////////////////////////////////////////////////////////////////////
	// storage, no reset needed on the data
	always_ff @(posedge core_clk_i) begin
		if (ce_i && wr.valid && !full) begin
			mem[wptr[AW-1:0]] <= wr.data;
		end
	end

	// pointers
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wptr <= '0;
			rptr <= '0;
		end else if (ce_i) begin
			if (wr.valid && !full) begin
				wptr <= wptr + 1'b1;
			end
			if (rd.ready && !empty) begin
				rptr <= rptr + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

//--- rtl/sscr_responder.sv
// sscr_responder: slave side of the sensor serial link; parses request frames,
// drives test and reset requests and queues checksummed replies through a fifo.
// assumes rx_i is synchronous to core_clk_i and the line idles high.
// Operation
// - fault byte: chip, gain, offset, feedback, oscillator, config faults in bits 5..0.
// - config byte bit 3 shows the standard in use; bits 7..4 zero.
// - config byte bit 2: 0 internal RC clock, 1 external oscillator.
// - config byte bit 1: 0 SPI enabled, 1 SPI disabled.
// - config byte bit 0: 0 reclose via test input, 1 automatic.
// - code 0x04 starts a functional test, replies one result byte.
// - result 0x00 failure, 0x01 accepted, 0x02 test or reset already running.
// - code 0x05 starts a measurement reset, replies one result byte.
// - code 0x07 replies first, then restarts the controller.
// - code 0x11 sets a new address; reply holds result and new address.
// - address-change reply carries the previous address.
// - broadcast address change is carried out without any reply.
// - address-change result 0x00 on failure or new address zero, else 0x01.
// - code 0x20 returns marker, four digits, marker, major and minor version.
// - frame is address, code, length, data, CRC high first; bad CRC unanswered.
// - link runs 19.2 kbps, 8N1, least significant bit first.
// - idle over two byte times ends a frame; reply starts within 20 ms.
`timescale 1ns/1ps
`default_nettype none
module sscr_responder
	import sscr_pkg::*;
#(
	parameter int unsigned BIT_CYC   = sscr_pkg::BIT_CYCLES,
	parameter logic [7:0]  ID_MARK_A = 8'h41, // arbitrary value
	parameter logic [7:0]  ID_DIG3   = 8'h01, // arbitrary value
	parameter logic [7:0]  ID_DIG2   = 8'h02, // arbitrary value
	parameter logic [7:0]  ID_DIG1   = 8'h03, // arbitrary value
	parameter logic [7:0]  ID_DIG0   = 8'h04, // arbitrary value
	parameter logic [7:0]  ID_MARK_B = 8'h42, // arbitrary value
	parameter logic [7:0]  ID_MAJOR  = 8'h02, // arbitrary value
	parameter logic [7:0]  ID_MINOR  = 8'h00  // arbitrary value
) (
	input  wire logic       core_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       ce_i,
	input  wire logic       rx_i,
	output logic            tx_o,
	output logic            tx_en_o,
	input  wire logic       chip_fault_i,
	input  wire logic       gain_fault_i,
	input  wire logic       offset_fault_i,
	input  wire logic       feedback_fault_i,
	input  wire logic       osc_fault_i,
	input  wire logic       cfg_fault_i,
	input  wire logic       std_sel_i,
	input  wire logic       ext_clk_i,
	input  wire logic       spi_off_i,
	input  wire logic       auto_reclose_i,
	input  wire logic       busy_i,
	output logic            test_req_o,
	output logic            meas_reset_req_o,
	output logic            restart_o,
	output logic [7:0]      fault_status_byte_o,
	output logic [7:0]      configuration_status_byte_o,
	output logic [7:0]      slave_addr_o
);
	import sscr_pkg::*;

	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} sscr_rx_type;
	typedef enum {G_IDLE, G_SEND, G_CRCH, G_CRCL, G_DRAIN} sscr_gen_type;

	localparam logic [19:0] BIT_C  = 20'(BIT_CYC);
	localparam logic [19:0] HALF_C = 20'(BIT_CYC / 2);
	localparam logic [19:0] GAP_C  = 20'(BIT_CYC * BITS_PER_BYTE * GAP_BYTE_TIMES);
	localparam logic [3:0]  LAST_DATA_BIT = 4'(DATA_BITS - 1);
	localparam logic [3:0]  TX_BITS       = 4'(BITS_PER_BYTE);

	sscr_stream_if #(.W(FIFO_WIDTH)) push_if ();
	sscr_stream_if #(.W(FIFO_WIDTH)) pop_if ();

	sscr_rx_type  rx_st;
	sscr_gen_type g_st;
	logic [19:0]  rx_cnt;
	logic [3:0]   rx_bits;
	logic [7:0]   rx_sh;
	logic         byte_stb;
	logic [7:0]   byte_val;
	logic         frame_open;
	logic         frame_end;
	logic [19:0]  gap_cnt;
	logic [8:0]   nbytes;
	logic         frame_bad;
	logic [7:0]   b_addr;
	logic [7:0]   b_code;
	logic [7:0]   b_len;
	logic [7:0]   b_d0;
	logic [15:0]  last2;
	logic [15:0]  crc;
	logic [15:0]  crc_d1;
	logic [15:0]  crc_d2;
	logic         frame_ok;
	logic         own;
	logic [7:0]   addr;
	logic [7:0]   rep_addr;
	logic [7:0]   rep_code;
	logic [7:0]   rep_len;
	logic [7:0]   rep_d0;
	logic [7:0]   rep_d1;
	logic [3:0]   idx;
	logic [15:0]  gcrc;
	logic         restart_pend;
	logic [7:0]   gen_byte;
	logic         push_fire;
	logic [19:0]  tx_cnt;
	logic [3:0]   tx_bits;
	logic [9:0]   tx_sh;
	logic         tx_busy;

	////////////////////////////////////////////////////////////////////////////////
	// status bytes, sampled from the measurement core
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fault_status_byte_o         <= 8'h00;
			configuration_status_byte_o <= 8'h00;
		end else if (ce_i) begin
			fault_status_byte_o                <= 8'h00;
			fault_status_byte_o[FLT_CHIP_BIT]  <= chip_fault_i;
			fault_status_byte_o[FLT_GAIN_BIT]  <= gain_fault_i;
			fault_status_byte_o[FLT_OFFS_BIT]  <= offset_fault_i;
			fault_status_byte_o[FLT_FDBK_BIT]  <= feedback_fault_i;
			fault_status_byte_o[FLT_OSC_BIT]   <= osc_fault_i;
			fault_status_byte_o[FLT_CFG_BIT]   <= cfg_fault_i;
			configuration_status_byte_o               <= 8'h00;
			configuration_status_byte_o[CFG_STD_BIT]  <= std_sel_i;
			configuration_status_byte_o[CFG_CLK_BIT]  <= ext_clk_i;
			configuration_status_byte_o[CFG_SPI_BIT]  <= spi_off_i;
			configuration_status_byte_o[CFG_RECL_BIT] <= auto_reclose_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// receiver: start bit checked at mid-bit, data shifted in lsb first
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_st    <= RX_IDLE;
			rx_cnt   <= 20'h00000;
			rx_bits  <= 4'h0;
			rx_sh    <= 8'h00;
			byte_stb <= 1'b0;
			byte_val <= 8'h00;
		end else if (ce_i) begin
			byte_stb <= 1'b0;
			unique case (rx_st)
				RX_IDLE: begin
					rx_cnt <= 20'h00000;
					if (!rx_i) begin
						rx_st <= RX_START;
					end
				end
				RX_START: begin
					if (rx_cnt == HALF_C - 20'h00001) begin
						rx_cnt  <= 20'h00000;
						rx_bits <= 4'h0;
						rx_st   <= rx_i ? RX_IDLE : RX_DATA; // glitch rejected
					end else begin
						rx_cnt <= rx_cnt + 20'h00001;
					end
				end
				RX_DATA: begin
					if (rx_cnt == BIT_C - 20'h00001) begin
						rx_cnt <= 20'h00000;
						rx_sh  <= {rx_i, rx_sh[7:1]};
						if (rx_bits == LAST_DATA_BIT) begin
							rx_st <= RX_STOP;
						end else begin
							rx_bits <= rx_bits + 4'h1;
						end
					end else begin
						rx_cnt <= rx_cnt + 20'h00001;
					end
				end
				RX_STOP: begin
					if (rx_cnt == BIT_C - 20'h00001) begin
						rx_st    <= RX_IDLE;
						byte_stb <= rx_i; // a missing stop bit drops the byte
						byte_val <= rx_sh;
					end else begin
						rx_cnt <= rx_cnt + 20'h00001;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// frame end on line idle longer than two byte times
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			gap_cnt    <= 20'h00000;
			frame_open <= 1'b0;
			frame_end  <= 1'b0;
		end else if (ce_i) begin
			frame_end <= 1'b0;
			if (byte_stb) begin
				frame_open <= 1'b1;
				gap_cnt    <= 20'h00000;
			end else if (rx_st != RX_IDLE) begin
				gap_cnt <= 20'h00000;
			end else if (frame_open) begin
				if (gap_cnt == GAP_C) begin
					frame_open <= 1'b0;
					frame_end  <= 1'b1;
				end else begin
					gap_cnt <= gap_cnt + 20'h00001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// header capture and running checksum, lagged two bytes behind
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			nbytes <= 9'h000;
			b_addr <= 8'h00;
			b_code <= 8'h00;
			b_len  <= 8'h00;
			b_d0   <= 8'h00;
			last2  <= 16'h0000;
			crc    <= CRC_INIT;
			crc_d1 <= CRC_INIT;
			crc_d2 <= CRC_INIT;
		end else if (ce_i && byte_stb) begin
			last2 <= {last2[7:0], byte_val};
			if (!frame_open) begin
				nbytes <= 9'h001;
				b_addr <= byte_val;
				crc    <= sscr_crc_byte(CRC_INIT, byte_val);
				crc_d1 <= CRC_INIT;
				crc_d2 <= CRC_INIT;
			end else begin
				if (nbytes != BYTE_CNT_MAX) begin
					nbytes <= nbytes + 9'h001;
				end
				if (nbytes == 9'h001) b_code <= byte_val;
				if (nbytes == 9'h002) b_len <= byte_val;
				if (nbytes == 9'h003) b_d0 <= byte_val;
				crc    <= sscr_crc_byte(crc, byte_val);
				crc_d1 <= crc;
				crc_d2 <= crc_d1;
			end
		end
	end

	// good frame: length matches and received checksum equals computed one
	assign frame_ok = (nbytes == {1'b0, b_len} + FRAME_OVERHEAD)
	                  && (crc_d2 == last2);
	assign own      = (b_addr == addr) && (addr != BCAST_ADDR);
	assign frame_bad = (nbytes == BYTE_CNT_MAX); // counter saturated: runaway frame

	////////////////////////////////////////////////////////////////////////////////
	// command decode; frames arriving while a reply is pending are dropped
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			addr             <= DEFAULT_ADDR;
			g_st             <= G_IDLE;
			rep_addr         <= 8'h00;
			rep_code         <= 8'h00;
			rep_len          <= 8'h00;
			rep_d0           <= 8'h00;
			rep_d1           <= 8'h00;
			idx              <= 4'h0;
			gcrc             <= CRC_INIT;
			restart_pend     <= 1'b0;
			test_req_o       <= 1'b0;
			meas_reset_req_o <= 1'b0;
			restart_o        <= 1'b0;
		end else if (ce_i) begin
			test_req_o       <= 1'b0;
			meas_reset_req_o <= 1'b0;
			restart_o        <= 1'b0;
			unique case (g_st)
				G_IDLE: begin
					idx      <= 4'h0;
					gcrc     <= CRC_INIT;
					rep_addr <= addr;
					rep_code <= b_code;
					if (frame_end && frame_ok && !frame_bad) begin
						if ((b_code == CODE_TEST || b_code == CODE_MRST)
						    && own && b_len == LEN_NONE) begin
							rep_len <= LEN_ONE;
							rep_d0  <= busy_i ? RES_BUSY : RES_ACCEPT;
							test_req_o       <= !busy_i && b_code == CODE_TEST;
							meas_reset_req_o <= !busy_i && b_code == CODE_MRST;
							g_st    <= G_SEND;
						end else if (b_code == CODE_RESTART && own && b_len == LEN_NONE) begin
							rep_len      <= LEN_ONE;
							rep_d0       <= RES_ACCEPT;
							restart_pend <= 1'b1;
							g_st         <= G_SEND;
						end else if (b_code == CODE_ADDR && b_len == LEN_ONE
						             && (own || b_addr == BCAST_ADDR)) begin
							rep_len <= LEN_TWO;
							rep_d0  <= (b_d0 == BCAST_ADDR) ? RES_FAIL : RES_ACCEPT;
							rep_d1  <= b_d0;
							if (b_d0 != BCAST_ADDR) begin
								addr <= b_d0;
							end
							if (own) begin
								g_st <= G_SEND;
							end
						end else if (b_code == CODE_IDENT && own && b_len == LEN_NONE) begin
							rep_len <= LEN_IDENT;
							g_st    <= G_SEND;
						end
					end
				end
				G_SEND: begin
					if (push_fire) begin
						gcrc <= sscr_crc_byte(gcrc, gen_byte);
						idx  <= idx + 4'h1;
						if (idx == 4'(rep_len) + 4'h2) begin
							g_st <= G_CRCH;
						end
					end
				end
				G_CRCH: begin
					if (push_fire) g_st <= G_CRCL;
				end
				G_CRCL: begin
					if (push_fire) g_st <= restart_pend ? G_DRAIN : G_IDLE;
				end
				G_DRAIN: begin
					// restart only after the last stop bit has left
					if (!pop_if.valid && !tx_busy) begin
						restart_o    <= 1'b1;
						restart_pend <= 1'b0;
						g_st         <= G_IDLE;
					end
				end
			endcase
		end
	end

	assign slave_addr_o = addr;

	////////////////////////////////////////////////////////////////////////////////
	// reply byte selection by position
	always_comb begin
		gen_byte = 8'h00;
		unique case (g_st)
			G_CRCH: gen_byte = gcrc[15:8];
			G_CRCL: gen_byte = gcrc[7:0];
			default: begin
				if (idx == 4'h0) gen_byte = rep_addr;
				else if (idx == 4'h1) gen_byte = rep_code;
				else if (idx == 4'h2) gen_byte = rep_len;
				else if (rep_code == CODE_IDENT) begin
					unique case (idx)
						4'h3: gen_byte = ID_MARK_A;
						4'h4: gen_byte = ID_DIG3;
						4'h5: gen_byte = ID_DIG2;
						4'h6: gen_byte = ID_DIG1;
						4'h7: gen_byte = ID_DIG0;
						4'h8: gen_byte = ID_MARK_B;
						4'h9: gen_byte = ID_MAJOR;
						default: gen_byte = ID_MINOR;
					endcase
				end else gen_byte = (idx == 4'h3) ? rep_d0 : rep_d1;
			end
		endcase
	end

	assign push_if.valid = (g_st == G_SEND) || (g_st == G_CRCH) || (g_st == G_CRCL);
	assign push_if.data  = gen_byte;
	assign push_fire     = push_if.valid && push_if.ready;

	// eight-byte reply queue; a full queue stalls the reply generator
	sscr_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.ce_i       (ce_i),
		.wr         (push_if.snk),
		.rd         (pop_if.src)
	);

	////////////////////////////////////////////////////////////////////////////////
	// transmitter: start, eight data bits lsb first, stop
	assign pop_if.ready = !tx_busy;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_busy <= 1'b0;
			tx_cnt  <= 20'h00000;
			tx_bits <= 4'h0;
			tx_sh   <= 10'h3ff;
			tx_o    <= 1'b1;
			tx_en_o <= 1'b0;
		end else if (ce_i) begin
			if (!tx_busy) begin
				tx_o    <= 1'b1;
				tx_en_o <= pop_if.valid;
				if (pop_if.valid) begin
					tx_busy <= 1'b1;
					tx_sh   <= {1'b1, pop_if.data, 1'b0};
					tx_cnt  <= 20'h00000;
					tx_bits <= 4'h0;
				end
			end else begin
				tx_en_o <= 1'b1;
				tx_o    <= tx_sh[0];
				if (tx_cnt == BIT_C - 20'h00001) begin
					tx_cnt <= 20'h00000;
					tx_sh  <= {1'b1, tx_sh[9:1]};
					if (tx_bits == TX_BITS - 4'h1) begin
						tx_busy <= 1'b0;
					end else begin
						tx_bits <= tx_bits + 4'h1;
					end
				end else begin
					tx_cnt <= tx_cnt + 20'h00001;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- sim/sscr_responder_props.sv
// sscr_responder_props: port-level checks for the serial command responder.
// assumes one clock domain; bound onto every instance of the responder.
`timescale 1ns/1ps
`default_nettype none
module sscr_responder_props (
	input  wire logic       core_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       ce_i,
	input  wire logic       tx_o,
	input  wire logic       tx_en_o,
	input  wire logic       chip_fault_i,
	input  wire logic       gain_fault_i,
	input  wire logic       offset_fault_i,
	input  wire logic       feedback_fault_i,
	input  wire logic       osc_fault_i,
	input  wire logic       cfg_fault_i,
	input  wire logic       std_sel_i,
	input  wire logic       ext_clk_i,
	input  wire logic       spi_off_i,
	input  wire logic       auto_reclose_i,
	input  wire logic       busy_i,
	input  wire logic       test_req_o,
	input  wire logic       meas_reset_req_o,
	input  wire logic       restart_o,
	input  wire logic [7:0] fault_status_byte_o,
	input  wire logic [7:0] configuration_status_byte_o,
	input  wire logic [7:0] slave_addr_o
);
	//////////////////////////////////////////////////
	// status bytes lag their inputs by one cycle; skip the edge right after reset
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	property p_fault_map;
		$past(nrst_i) && $past(ce_i) |-> fault_status_byte_o == {2'b00, $past(chip_fault_i),
		$past(gain_fault_i), $past(offset_fault_i), $past(feedback_fault_i),
		$past(osc_fault_i), $past(cfg_fault_i)};
	endproperty
	a_fault_map: assert property (p_fault_map) else $error("fault byte wrong");
	property p_cfg_map;
		$past(nrst_i) && $past(ce_i) |-> configuration_status_byte_o == {4'h0,
		$past(std_sel_i), $past(ext_clk_i), $past(spi_off_i), $past(auto_reclose_i)};
	endproperty
	a_cfg_map: assert property (p_cfg_map) else $error("config byte wrong");
	property p_tx_idle; !tx_en_o |-> tx_o; endproperty
	a_tx_idle: assert property (p_tx_idle) else $error("line not idle high");
	property p_test_pulse; test_req_o |=> !test_req_o; endproperty
	a_test_pulse: assert property (p_test_pulse) else $error("test pulse too long");
	property p_meas_pulse; meas_reset_req_o |=> !meas_reset_req_o; endproperty
	a_meas_pulse: assert property (p_meas_pulse) else $error("reset pulse too long");
	property p_req_busy; test_req_o || meas_reset_req_o |-> !$past(busy_i); endproperty
	a_req_busy: assert property (p_req_busy) else $error("request while busy");
	property p_req_one; $onehot0({test_req_o, meas_reset_req_o, restart_o}); endproperty
	a_req_one: assert property (p_req_one) else $error("two requests at once");
	// restart lands in the cycle the driver lets go, right after the full stop bit
	property p_restart_quiet; restart_o |-> tx_o && !tx_en_o && $past(tx_o); endproperty
	a_restart_quiet: assert property (p_restart_quiet) else $error("restart mid reply");
	property p_addr_nonzero; slave_addr_o != 8'h00; endproperty
	a_addr_nonzero: assert property (p_addr_nonzero) else $error("address became zero");
endmodule
bind sscr_responder sscr_responder_props sscr_responder_props_i (
	.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .tx_o(tx_o), .tx_en_o(tx_en_o),
	.chip_fault_i(chip_fault_i), .gain_fault_i(gain_fault_i), .offset_fault_i(offset_fault_i),
	.feedback_fault_i(feedback_fault_i), .osc_fault_i(osc_fault_i), .cfg_fault_i(cfg_fault_i),
	.std_sel_i(std_sel_i), .ext_clk_i(ext_clk_i), .spi_off_i(spi_off_i), .busy_i(busy_i),
	.auto_reclose_i(auto_reclose_i), .test_req_o(test_req_o), .restart_o(restart_o),
	.meas_reset_req_o(meas_reset_req_o), .fault_status_byte_o(fault_status_byte_o),
	.configuration_status_byte_o(configuration_status_byte_o), .slave_addr_o(slave_addr_o));
`default_nettype wire

//--- sim/sscr_master_model.sv
// sscr_master_model: bus master on the serial link; sends framed requests, collects replies.
// assumes one clock and a bit time shortened to BIT_CYC cycles.
`timescale 1ns/1ps
`default_nettype none
module sscr_master_model #(
	parameter int unsigned BIT_CYC = 16,
	parameter int unsigned REQ_GAP = 1000
) (
	input  wire logic core_clk_i,
	input  wire logic line_i,
	output logic      line_o
);
	logic [7:0] got[$];
	logic [7:0] r;
	initial line_o = 1'b1; // line idles high between frames
	//////////////////////////////////////////////////
	// bitwise checksum, reflected form, zero start
	function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'h0000;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction
	// bad flips one checksum bit so the slave must stay silent
	task automatic send(input logic [7:0] b[$], input logic bad);
		logic [15:0] c;
		c = crc_of(b) ^ {15'h0000, bad};
		b.push_back(c[15:8]);
		b.push_back(c[7:0]);
		foreach (b[i]) begin
			for (int k = 0; k < 10; k++) begin
				line_o <= k == 0 ? 1'b0 : k == 9 ? 1'b1 : b[i][k - 1];
				repeat (BIT_CYC) @(posedge core_clk_i);
			end
		end
		// gap scaled down with the bit time, still far above the frame gap
		repeat (REQ_GAP) @(posedge core_clk_i);
	endtask
	// reply catcher: centre-samples each bit, lsb first
	always begin
		@(negedge line_i);
		repeat (BIT_CYC / 2) @(posedge core_clk_i);
		for (int k = 0; k < 8; k++) begin
			repeat (BIT_CYC) @(posedge core_clk_i);
			r[k] = line_i;
		end
		repeat (BIT_CYC) @(posedge core_clk_i);
		got.push_back(line_i ? r : 8'hxx); // broken stop bit shows as unknown
	end
endmodule
`default_nettype wire

//--- sim/sscr_responder_test.sv
// sscr_responder_test: scenario bench for the serial command responder.
// assumes the master model on the link and default identity values.
`timescale 1ns/1ps
`default_nettype none
module sscr_responder_test;
	import sscr_pkg::*;
	localparam int unsigned BC = 16;
	logic       core_clk_i = 1'b0;
	logic       nrst_i = 1'b0;
	logic       busy = 1'b0;
	logic [5:0] flt = 6'h00;
	logic [3:0] cfg = 4'h0;
	logic       rx, tx, tx_en, test_req, meas_req, restart;
	logic [7:0] fsb, csb, addr;
	int         n_test = 0, n_meas = 0, n_rst = 0, mismatches = 0, checks = 0;
	always #2.5 core_clk_i = ~core_clk_i;
	// pulse counters, outputs are registered so the pre-edge value is read
	always @(posedge core_clk_i) begin
		if (test_req === 1'b1) n_test++;
		if (meas_req === 1'b1) n_meas++;
		if (restart === 1'b1) n_rst++;
	end
	sscr_responder #(.BIT_CYC(BC)) sscr_responder_i (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
		.ce_i(1'b1), .rx_i(rx), .tx_o(tx), .tx_en_o(tx_en), .chip_fault_i(flt[5]),
		.gain_fault_i(flt[4]), .offset_fault_i(flt[3]), .feedback_fault_i(flt[2]),
		.osc_fault_i(flt[1]), .cfg_fault_i(flt[0]), .std_sel_i(cfg[3]), .ext_clk_i(cfg[2]),
		.spi_off_i(cfg[1]), .auto_reclose_i(cfg[0]), .busy_i(busy), .test_req_o(test_req),
		.meas_reset_req_o(meas_req), .restart_o(restart), .fault_status_byte_o(fsb),
		.configuration_status_byte_o(csb), .slave_addr_o(addr));
	sscr_master_model #(.BIT_CYC(BC)) sscr_master_model_i (.core_clk_i(core_clk_i),
		.line_i(tx), .line_o(rx));
	//////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// waits for a whole reply, checksum appended from the expected bytes
	task automatic reply(input logic [7:0] e[$]);
		logic [15:0] c;
		int n;
		c = sscr_master_model_i.crc_of(e);
		e.push_back(c[15:8]);
		e.push_back(c[7:0]);
		n = 0;
		while (sscr_master_model_i.got.size() < e.size() && n < 5000) begin
			@(posedge core_clk_i);
			n++;
		end
		if (n == 5000) begin
			mismatches++;
			summarize();
		end
		foreach (e[i]) check(sscr_master_model_i.got[i], e[i]);
		sscr_master_model_i.got.delete();
	endtask
	task automatic s_status();
		for (int i = 0; i < 6; i++) begin
			@(posedge core_clk_i);
			flt <= 6'h01 << i;
			cfg <= 4'h1 << (i % 4);
			repeat (3) @(posedge core_clk_i);
			check(fsb, {2'b00, 6'h01 << i});
			check(csb, {4'h0, 4'h1 << (i % 4)});
		end
	endtask
	// foreign address, broadcast and damaged checksum all stay unanswered
	task automatic s_silent();
		sscr_master_model_i.send('{8'h21, CODE_TEST, 8'h00}, 1'b0);
		sscr_master_model_i.send('{8'h00, CODE_TEST, 8'h00}, 1'b0);
		sscr_master_model_i.send('{8'h64, CODE_TEST, 8'h00}, 1'b1);
		check(8'(sscr_master_model_i.got.size()), 8'h00);
		check(8'(n_test), 8'h00);
	endtask
	task automatic s_cmd();
		logic [7:0] code;
		for (int i = 0; i < 4; i++) begin
			code = i[1] ? CODE_MRST : CODE_TEST;
			@(posedge core_clk_i);
			busy <= i[0];
			n_test = 0;
			n_meas = 0;
			sscr_master_model_i.send('{8'h64, code, 8'h00}, 1'b0);
			reply('{8'h64, code, 8'h01, i[0] ? RES_BUSY : RES_ACCEPT});
			check(8'(n_test), {7'h00, ~i[1] & ~i[0]});
			check(8'(n_meas), {7'h00, i[1] & ~i[0]});
		end
	endtask
	task automatic s_restart();
		sscr_master_model_i.send('{8'h64, CODE_RESTART, 8'h00}, 1'b0);
		reply('{8'h64, CODE_RESTART, 8'h01, RES_ACCEPT});
		repeat (BC * 2) @(posedge core_clk_i);
		check(8'(n_rst), 8'h01);
	endtask
	task automatic s_ident();
		sscr_master_model_i.send('{8'h64, CODE_IDENT, 8'h00}, 1'b0);
		reply('{8'h64, CODE_IDENT, 8'h08, 8'h41, 8'h01, 8'h02, 8'h03, 8'h04, 8'h42, 8'h02,
			8'h00});
	endtask
	task automatic s_addr();
		sscr_master_model_i.send('{8'h64, CODE_ADDR, 8'h01, 8'h00}, 1'b0);
		reply('{8'h64, CODE_ADDR, 8'h02, RES_FAIL, 8'h00});
		sscr_master_model_i.send('{8'h64, CODE_ADDR, 8'h01, 8'h33}, 1'b0);
		reply('{8'h64, CODE_ADDR, 8'h02, RES_ACCEPT, 8'h33});
		check(addr, 8'h33);
		sscr_master_model_i.send('{8'h00, CODE_ADDR, 8'h01, 8'h5a}, 1'b0);
		check(8'(sscr_master_model_i.got.size()), 8'h00);
		check(addr, 8'h5a);
	endtask
	//////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		@(posedge core_clk_i);
		check(addr, DEFAULT_ADDR);
		s_status();
		s_silent();
		s_cmd();
		s_restart();
		s_ident();
		s_addr();
		summarize();
	end
endmodule
`default_nettype wire
